//--- rtl/dio_consts.vh
// Constants for the isolated digital input and output port.
`ifndef DIO_CONSTS_VH
`define DIO_CONSTS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define ADDR_W             4
`define REG_IN_DATA        4'h0
`define REG_IN_CTRL        4'h1
`define REG_RATE_DIV       4'h2
`define REG_OUT_DATA0      4'h3
`define REG_OUT_DATA1      4'h4
`define REG_OUT_STAT       4'h5
`define REG_PREPARE        4'h6

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_RUN_BIT       0
`define STAT_ACT0_BIT      0
`define STAT_ACT1_BIT      1
`define STAT_BUSY0_BIT     2
`define STAT_BUSY1_BIT     3
`define STAT_RANGE0_BIT    4
`define STAT_RANGE1_BIT    5
`define STAT_OD0_BIT       6
`define STAT_OD1_BIT       7

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define RATE_DIV_RESET     32'h0000_2710
`define SAMPLE_MAX_HZ      10000
`define CLK_HZ             100000000
`define MIN_DIV            (`CLK_HZ / `SAMPLE_MAX_HZ)
`define SWITCH_TIME_NS     165000
`define CLK_PERIOD_NS      10
`define SWITCH_CYCLES      ((`SWITCH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OUT_INIT_VALUE     8'h00

`endif

//--- rtl/out_group.v
// One eight-bit isolated output group with its driver control.
`timescale 1ns/1ns
`include "dio_consts.vh"

module out_group #(
  parameter WIDTH       = 8,
  parameter HOLD_CYCLES = `SWITCH_CYCLES
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire             wr,
  input  wire [WIDTH-1:0] wdata,
  input  wire             activate,
  input  wire             open_drain,
  output reg  [WIDTH-1:0] value,
  output reg              active,
  output wire             busy,
  output reg  [WIDTH-1:0] high_on,
  output reg  [WIDTH-1:0] low_on
);

  reg  [17:0]      hold;
  reg              pend;
  reg  [WIDTH-1:0] pend_val;
  wire             upd;
  wire [WIDTH-1:0] new_val;

  assign busy    = (hold != 18'h00000);
  // A write during the switching time is kept and applied once it ends.
  assign upd     = !busy && (wr || pend || (activate && !active));
  assign new_val = wr ? wdata : (pend ? pend_val : `OUT_INIT_VALUE);

  always @(posedge clk) begin
    if (!nrst) begin
      value    <= `OUT_INIT_VALUE;
      active   <= 1'b0;
      pend     <= 1'b0;
      pend_val <= `OUT_INIT_VALUE;
      hold     <= 18'h00000;
      high_on  <= {WIDTH{1'b0}};
      low_on   <= {WIDTH{1'b0}};
    end else begin
      if (busy) begin
        hold <= hold - 18'h00001;
        if (wr) begin
          pend     <= 1'b1;
          pend_val <= wdata;
        end
      end
      if (upd) begin
        value   <= new_val;
        active  <= 1'b1;
        pend    <= 1'b0;
        hold    <= HOLD_CYCLES[17:0];
        // High and low switches go straight from their old state to the new value; in open drain the high switch stays off.
        high_on <= open_drain ? {WIDTH{1'b0}} : new_val;
        low_on  <= ~new_val;
      end else if (active) begin
        high_on <= open_drain ? {WIDTH{1'b0}} : value;
        low_on  <= ~value;
      end
    end
  end

endmodule

//--- rtl/dio_port.v
// Sampled digital input port and strapped digital output port.
`timescale 1ns/1ns
`include "dio_consts.vh"

module dio_port #(
  parameter GROUPS   = 2,
  parameter GW       = 8,
  parameter RATE_DIV = `RATE_DIV_RESET,
  parameter HOLD     = `SWITCH_CYCLES
) (
  input  wire                 clk,
  input  wire                 nrst,
  input  wire [`ADDR_W-1:0]   addr,
  input  wire [31:0]          wdata,
  input  wire                 wr,
  input  wire                 rd,
  output reg  [31:0]          rdata,
  input  wire [GROUPS*GW-1:0] din,
  input  wire [GROUPS-1:0]    range_strap_n,
  input  wire [GROUPS-1:0]    driver_type_select,
  output wire [GROUPS-1:0]    range_low,
  output wire [GROUPS*GW-1:0] dout,
  output wire [GROUPS*GW-1:0] dout_oe_n,
  output wire [GROUPS*GW-1:0] high_side_on,
  output wire [GROUPS*GW-1:0] low_side_on,
  output reg                  sample_strobe
);

  // ****************************************************************
  // Input sampling
  // ****************************************************************
  reg  [31:0]          div;
  reg  [31:0]          cnt;
  reg                  run;
  reg  [GROUPS*GW-1:0] catch;
  reg  [GROUPS*GW-1:0] sample;
  reg  [GROUPS-1:0]    range_q;
  wire                 tick;
  wire [31:0]          div_eff;

  // Rates above the maximum are clamped rather than refused.
  assign div_eff = (div < `MIN_DIV) ? `MIN_DIV : div;
  assign tick    = run && (cnt >= div_eff - 32'h1);
  // A strap tied to the group ground reads low; open reads high range.
  assign range_low = range_q;

  always @(posedge clk) begin
    if (!nrst) begin
      cnt           <= 32'h0;
      catch         <= {GROUPS*GW{1'b0}};
      sample        <= {GROUPS*GW{1'b0}};
      sample_strobe <= 1'b0;
      range_q       <= {GROUPS{1'b0}};
    end else begin
      range_q       <= ~range_strap_n;
      sample_strobe <= tick;
      if (tick) begin
        cnt    <= 32'h0;
        sample <= catch | din;
        catch  <= {GROUPS*GW{1'b0}};
      end else begin
        cnt   <= run ? cnt + 32'h1 : 32'h0;
        catch <= catch | din;
      end
    end
  end

  // ****************************************************************
  // Output groups
  // ****************************************************************
  reg              prep;
  wire [GROUPS-1:0] act;
  wire [GROUPS-1:0] busy;
  wire [GROUPS*GW-1:0] val;

  genvar g;
  generate
    for (g = 0; g < GROUPS; g = g + 1) begin : grp
      wire gwr;
      assign gwr = wr && (addr == `REG_OUT_DATA0 + g);
      out_group #(
        .WIDTH       (GW),
        .HOLD_CYCLES (HOLD)
      ) u_grp (
        .clk        (clk),
        .nrst       (nrst),
        .wr         (gwr),
        .wdata      (wdata[GW-1:0]),
        .activate   (prep),
        .open_drain (driver_type_select[g]),
        .value      (val[g*GW +: GW]),
        .active     (act[g]),
        .busy       (busy[g]),
        .high_on    (high_side_on[g*GW +: GW]),
        .low_on     (low_side_on[g*GW +: GW])
      );
      // Pin drives only where a switch is on; otherwise it floats.
      assign dout[g*GW +: GW]      = val[g*GW +: GW];
      assign dout_oe_n[g*GW +: GW] = ~(high_side_on[g*GW +: GW] | low_side_on[g*GW +: GW]);
    end
  endgenerate

  // ****************************************************************
  // Register bus
  // ****************************************************************
  always @(posedge clk) begin
    if (!nrst) begin
      div   <= RATE_DIV;
      run   <= 1'b0;
      prep  <= 1'b0;
      rdata <= 32'h0;
    end else begin
      prep <= wr && (addr == `REG_PREPARE);
      if (wr && addr == `REG_IN_CTRL) begin
        run <= wdata[`CTRL_RUN_BIT];
      end
      if (wr && addr == `REG_RATE_DIV) begin
        div <= wdata;
      end
      rdata <= 32'h0;
      if (rd) begin
        case (addr)
          `REG_IN_DATA:   rdata <= {{(32-GROUPS*GW){1'b0}}, sample};
          `REG_IN_CTRL:   rdata <= {31'h0, run};
          `REG_RATE_DIV:  rdata <= div;
          `REG_OUT_DATA0: rdata <= {24'h0, val[GW-1:0]};
          `REG_OUT_DATA1: rdata <= {24'h0, val[2*GW-1:GW]};
          `REG_OUT_STAT:  rdata <= {24'h0, driver_type_select, range_q, busy, act};
          default:        rdata <= 32'h0;
        endcase
      end
    end
  end

endmodule

//--- tb/dio_port_props.sv
// Checker on the pins of the digital port.
`timescale 1ns/1ns
module dio_port_props (
  input wire        clk,
  input wire        nrst,
  input wire [3:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire [1:0]  range_strap_n,
  input wire [1:0]  driver_type_select,
  input wire [1:0]  range_low,
  input wire [15:0] dout_oe_n,
  input wire [15:0] high_side_on,
  input wire [15:0] low_side_on,
  input wire        sample_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_reset_hiz: assert property (disable iff (1'b0) !nrst |=> (high_side_on | low_side_on) == 16'h0000)
    else $error("switch on in reset");
  a_no_shoot: assert property ((high_side_on & low_side_on) == 16'h0000)
    else $error("both switches on");
  a_oe_map: assert property (dout_oe_n == ~(high_side_on | low_side_on))
    else $error("enable mismatch");
  a_od_float: assert property (driver_type_select[1] [*3] |-> high_side_on[15:8] == 8'h00)
    else $error("open drain drives high");
  a_low_first: assert property (wr && addr == 4'h3 && wdata[7:0] == 8'h00 && &dout_oe_n[7:0] |=>
    high_side_on[7:0] == 8'h00 && low_side_on[7:0] == 8'hff) else $error("no direct low");
  a_hold_min: assert property ($changed(low_side_on[7:0]) |=> $stable(low_side_on[7:0]) [*8])
    else $error("update too soon");
  a_strobe_gap: assert property (sample_strobe |=> !sample_strobe [*8])
    else $error("sample too soon");
  a_range_map: assert property ($past(nrst) |-> range_low == ~$past(range_strap_n))
    else $error("range mismatch");
endmodule
bind dio_port dio_port_props dio_port_props_inst (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr(wr), .range_strap_n(range_strap_n), .driver_type_select(driver_type_select), .range_low(range_low),
  .dout_oe_n(dout_oe_n), .high_side_on(high_side_on), .low_side_on(low_side_on),
  .sample_strobe(sample_strobe));

//--- tb/dio_loads.sv
// Model of the relay loads on the output pins.
`timescale 1ns/1ns
module dio_loads (
  input  wire [15:0] high_side_on,
  input  wire [15:0] low_side_on,
  output wire [15:0] pin
);
  // A floating pin is pulled to the load rail, so open drain high reads 1.
  assign pin = high_side_on | ~low_side_on;
endmodule

//--- tb/dio_port_tb.sv
// Testbench for the isolated digital port.
`timescale 1ns/1ns
module dio_port_tb;
  logic        clk;
  logic        nrst;
  logic        wr;
  logic        rd;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic [15:0] din;
  wire  [31:0] rdata;
  wire  [1:0]  range_low;
  wire  [15:0] dout, oe_n, hi, lo, pin;
  wire         strobe;
  int          err_total = 0;
  int          compares = 0;
  dio_port #(.HOLD(20)) dio_port_inst (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .din(din), .range_strap_n(2'b10), .driver_type_select(2'b10),
    .range_low(range_low), .dout(dout), .dout_oe_n(oe_n), .high_side_on(hi), .low_side_on(lo),
    .sample_strobe(strobe));
  dio_loads dio_loads_inst (.high_side_on(hi), .low_side_on(lo), .pin(pin));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task end_sim;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // A lost sample must not hang the run.
  task wait_strobe;
    int i;
    for (i = 0; i < 12000 && strobe !== 1'b1; i++)
      @(negedge clk);
    if (i == 12000) begin
      chk(32'h0, 32'h1);
      end_sim;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    nrst  = 1'b0;
    wr    = 1'b0;
    rd    = 1'b0;
    addr  = 4'h0;
    wdata = 32'h0;
    din   = 16'h0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    #1 chk(32'(oe_n), 32'hffff);
    wreg(4'h3, 32'h0);
    #1 chk(32'({hi[7:0], lo[7:0]}), 32'h00ff);
    chk(32'(range_low), 32'h1);
    wreg(4'h3, 32'h5a);
    #1 chk(32'(lo[7:0]), 32'hff);
    repeat (30) @(posedge clk);
    #1 chk(32'({hi[7:0], lo[7:0]}), 32'h5aa5);
    wreg(4'h6, 32'h0);
    @(posedge clk);
    #1 chk(32'(lo[15:8]), 32'hff);
    repeat (30) @(posedge clk);
    wreg(4'h4, 32'h0f);
    #1 chk(32'({hi[15:8], pin[15:8]}), 32'h000f);
    repeat (30) @(posedge clk);
    #1 chk({hi, lo}, 32'h005af0a5);
    chk(32'(dout), 32'h0f5a);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    #1 chk(32'(oe_n), 32'hffff);
    $display("output tests done");
    wreg(4'h2, 32'h1);
    rreg(4'h2, 32'h1);
    rreg(4'hf, 32'h0);
    wreg(4'h1, 32'h1);
    din <= 16'h8001;
    @(posedge clk);
    din <= 16'h0;
    wait_strobe;
    rreg(4'h0, 32'h8001);
    wait_strobe;
    rreg(4'h0, 32'h0);
    $display("input tests done");
    end_sim;
  end
endmodule
